// ### htx_hdlc_transmit_controller.sv
// Purpose: HDLC transmit controller of one framer port
// Assumes: tx_slot comes from framer logic on core_clk, one strobe per line bit
// Notes: Avalon-MM slave answers every access after one wait cycle
//
// Functional notes
// R1: One flag between messages, two with flag_count_select.
// R2: Loop bit before last byte repeats the message.
// R3: Loop cleared: finish message, then flags until new data.
// R4: New message ends loop: flags, then new message.
// R5: Soft reset empties FIFO, sends abort, then fill.
// R6: Soft reset bit set by software, cleared by hardware.
// R7: Mapping select: channel, or data link when enabled.
// R8: Fill between messages is 7e or ff.
// R9: End-of-message bit before last byte closes the message.
// R10: Two CRC bytes end each message unless checksum_defeat.
// R11: Zero after five ones in the message unless stuffer_defeat.
// R12: Each suppress bit removes its channel bit.
// R13: Abort rising edge empties FIFO, sends one fe, then fill.
// R14: T1 only: send_bit_oriented_code sends the six-bit code.
// R15: Controller works only while controller_enable is set; the bit-oriented code is still inserted when it is clear.
// R16: Timeslot select takes effect only at a soft reset.
// R17: Port copy sits at base plus 200h times port index minus one.
// R18: Host bytes enter the FIFO and leave in order.
// R19: Control register one resets to zero.
//
// Chosen here: the Avalon-MM register port.
`include "htx_tx_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module htx_hdlc_transmit_controller #(
   parameter logic [3:0] PORT_NUM = 4'd1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Avalon-MM slave, word addressed
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output var logic [31:0] avs_readdata,
   output var logic avs_waitrequest,
   // Framer transmit timing
   input wire htx_pkg::htx_slot_t tx_slot,
   // HDLC bit toward the framer
   output var htx_pkg::htx_out_t tx_out
);

   // Port copy placement
   localparam logic [11:0] PORT_BASE = 12'(`HTX_PORT_STRIDE * 12'(PORT_NUM - 4'd1)); // R17

   // CRC-16 one bit step, LSB first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? `HTX_CRC_POLY : 16'h0000);
   endfunction

   // Software registers
   logic [7:0] ctrl1;
   logic [7:0] suppress;
   logic [7:0] ctrl2;
   logic [5:0] boc_code;
   logic [1:0] cfg;
   logic [4:0] active_ts;
   logic [7:0] rst_cnt;

   // FIFO storage; base_ptr marks the message in flight
   htx_pkg::htx_entry_t fifo_mem [0:63];
   logic [6:0] wr_ptr;
   logic [6:0] rd_ptr;
   logic [6:0] base_ptr;

   // Bit engine
   htx_pkg::htx_state_t state;
   logic [7:0] sreg;
   logic [3:0] bits_left;
   logic [2:0] ones;
   logic stuff_on;
   logic crc_on;
   logic [15:0] crc;
   logic cur_eom;
   logic cur_loop;
   logic [15:0] boc_sreg;

   // Bus decode
   logic req;
   logic bus_take;
   logic [11:0] reg_idx;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic wr_fifo;
   logic [31:0] rd_mux;
   assign req = avs_read | avs_write;
   assign bus_take = req & ~avs_waitrequest;
   assign reg_idx = avs_address - PORT_BASE; // R17
   assign wr_ctrl1 = bus_take & avs_write & (reg_idx == `HTX_IDX_CTRL1);
   assign wr_ctrl2 = bus_take & avs_write & (reg_idx == `HTX_IDX_CTRL2);
   assign wr_fifo = bus_take & avs_write & (reg_idx == `HTX_IDX_FIFO);

   // FIFO state
   logic [6:0] fill_cnt;
   logic fifo_full;
   logic fifo_empty;
   logic fifo_push;
   logic rst_busy;
   logic rst_start;
   logic rst_done;
   logic abort_edge;
   logic flush;
   assign fill_cnt = wr_ptr - base_ptr;
   assign fifo_full = fill_cnt[6];
   assign fifo_empty = (rd_ptr == wr_ptr);
   assign rst_busy = ctrl1[`HTX_B_SRST];
   assign fifo_push = wr_fifo & ~fifo_full & ~rst_busy; // R18
   assign rst_start = wr_ctrl1 & avs_writedata[`HTX_B_SRST] & ~rst_busy;
   assign rst_done = rst_busy & (rst_cnt == 8'h01);
   assign abort_edge = wr_ctrl2 & avs_writedata[`HTX_B_ABORT] & ~ctrl2[`HTX_B_ABORT]; // R13
   assign flush = abort_edge | rst_start; // R5 R13

   // Read mux; unmapped and write-only addresses read zero
   assign rd_mux = (reg_idx == `HTX_IDX_CTRL1) ? {24'h000000, ctrl1} :
                   (reg_idx == `HTX_IDX_SUPP) ? {24'h000000, suppress} :
                   (reg_idx == `HTX_IDX_BOC) ? {26'h0000000, boc_code} :
                   (reg_idx == `HTX_IDX_CTRL2) ? {24'h000000, ctrl2} :
                   (reg_idx == `HTX_IDX_CFG) ? {30'h00000000, cfg} :
                   (reg_idx == `HTX_IDX_STAT) ?
                      {20'h00000, state, fifo_full, fifo_empty, fill_cnt} :
                   32'h00000000;

   // Slot selection: unsuppressed channel bit, or data link bit
   logic slot_hit;
   logic boc_go;
   logic grant;
   assign slot_hit = ctrl1[`HTX_B_MAP] ?
                     (cfg[`HTX_B_FDLEN] & tx_slot.fdl_slot) : // R7
                     ((tx_slot.timeslot == active_ts) &
                      ~suppress[tx_slot.bit_index]); // R12
   assign boc_go = tx_slot.strobe & tx_slot.fdl_slot & ~cfg[`HTX_B_E1] &
                   ctrl2[`HTX_B_BOC]; // R14
   assign grant = tx_slot.strobe & ctrl2[`HTX_B_EN] & ~rst_busy & slot_hit & ~boc_go; // R15

   // Byte boundary and stuffing
   logic stuff_now;
   logic at_bound;
   logic rewind;
   logic [6:0] head_ptr;
   htx_pkg::htx_entry_t head;
   logic [7:0] fill_byte;
   assign stuff_now = stuff_on & (ones == 3'd5); // R11
   assign at_bound = (bits_left == 4'd0) & ~stuff_now;
   assign rewind = cur_loop & ctrl1[`HTX_B_LOOP] & fifo_empty; // R2 R3 R4
   assign head_ptr = ((state == htx_pkg::HTX_CLOSE) & rewind) ? base_ptr : rd_ptr;
   assign head = fifo_mem[head_ptr[5:0]];
   assign fill_byte = ctrl1[`HTX_B_FILL] ? `HTX_IDLE_BYTE : `HTX_FLAG_BYTE; // R8

   // Choice of the next byte at a boundary
   htx_pkg::htx_state_t nb_state;
   logic [7:0] nb_byte;
   logic nb_stuff;
   logic nb_crc;
   logic nb_pop;
   logic nb_start;
   always_comb begin
      nb_state = htx_pkg::HTX_IDLE;
      nb_byte = fill_byte;
      nb_stuff = 1'b0;
      nb_crc = 1'b0;
      nb_pop = 1'b0;
      nb_start = 1'b0;
      case (state)
         htx_pkg::HTX_IDLE: begin
            if (!fifo_empty) begin
               nb_state = htx_pkg::HTX_FLAG;
               nb_byte = `HTX_FLAG_BYTE;
            end
         end
         htx_pkg::HTX_FLAG: begin
            if (!fifo_empty) begin
               nb_state = htx_pkg::HTX_DATA;
               nb_byte = head.data;
               nb_stuff = ~ctrl1[`HTX_B_NOSTUFF]; // R11
               nb_crc = 1'b1;
               nb_pop = 1'b1;
               nb_start = 1'b1;
            end
         end
         htx_pkg::HTX_DATA: begin
            if (cur_eom && !ctrl1[`HTX_B_NOCRC]) begin // R9 R10
               nb_state = htx_pkg::HTX_CRC_LO;
               nb_byte = ~crc[7:0];
               nb_stuff = ~ctrl1[`HTX_B_NOSTUFF];
            end else if (cur_eom) begin // R9
               nb_state = htx_pkg::HTX_CLOSE;
               nb_byte = `HTX_FLAG_BYTE;
            end else if (!fifo_empty) begin // R18
               nb_state = htx_pkg::HTX_DATA;
               nb_byte = head.data;
               nb_stuff = ~ctrl1[`HTX_B_NOSTUFF];
               nb_crc = 1'b1;
               nb_pop = 1'b1;
            end else begin
               // Underrun cannot close cleanly, so abort
               nb_state = htx_pkg::HTX_ABORT;
               nb_byte = `HTX_ABORT_BYTE;
            end
         end
         htx_pkg::HTX_CRC_LO: begin
            nb_state = htx_pkg::HTX_CRC_HI;
            nb_byte = ~crc[15:8]; // R10
            nb_stuff = ~ctrl1[`HTX_B_NOSTUFF];
         end
         htx_pkg::HTX_CRC_HI: begin
            nb_state = htx_pkg::HTX_CLOSE;
            nb_byte = `HTX_FLAG_BYTE;
         end
         htx_pkg::HTX_CLOSE: begin
            if (!fifo_empty || rewind) begin
               if (ctrl1[`HTX_B_FLAGS2]) begin // R1 R4
                  nb_state = htx_pkg::HTX_FLAG;
                  nb_byte = `HTX_FLAG_BYTE;
               end else begin // R1
                  nb_state = htx_pkg::HTX_DATA;
                  nb_byte = head.data;
                  nb_stuff = ~ctrl1[`HTX_B_NOSTUFF];
                  nb_crc = 1'b1;
                  nb_pop = 1'b1;
                  nb_start = 1'b1;
               end
            end
         end
         default: begin
            nb_state = htx_pkg::HTX_IDLE;
         end
      endcase
   end

   // Source of the bit sent in this slot
   logic [7:0] src_byte;
   logic src_stuff;
   logic src_crc;
   logic [15:0] src_crcv;
   logic emit_bit;
   assign src_byte = at_bound ? nb_byte : sreg;
   assign src_stuff = at_bound ? nb_stuff : stuff_on;
   assign src_crc = at_bound ? nb_crc : crc_on;
   assign src_crcv = (at_bound & nb_start) ? `HTX_CRC_INIT : crc;
   assign emit_bit = stuff_now ? 1'b0 : src_byte[0];

   // Avalon handshake: one wait cycle, then the access is taken
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (req & avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // Software registers; a write setting soft reset wins over its self-clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl1 <= `HTX_RST_VAL; // R19
         suppress <= `HTX_RST_VAL;
         ctrl2 <= `HTX_RST_VAL;
         boc_code <= 6'h00;
         cfg <= 2'h0;
      end else begin
         if (wr_ctrl1) begin
            ctrl1 <= avs_writedata[7:0] | {2'h0, rst_busy & ~rst_done, 5'h00}; // R6
         end else if (rst_done) begin
            ctrl1[`HTX_B_SRST] <= 1'b0; // R6
         end else if (fifo_push) begin
            ctrl1[`HTX_B_EOM] <= 1'b0;
         end
         if (wr_ctrl2) begin
            ctrl2 <= avs_writedata[7:0];
         end
         if (bus_take & avs_write & (reg_idx == `HTX_IDX_SUPP)) begin
            suppress <= avs_writedata[7:0];
         end
         if (bus_take & avs_write & (reg_idx == `HTX_IDX_BOC)) begin
            boc_code <= avs_writedata[5:0];
         end
         if (bus_take & avs_write & (reg_idx == `HTX_IDX_CFG)) begin
            cfg <= avs_writedata[1:0];
         end
      end
   end

   // Soft reset sequencer; the timeslot is latched only here
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_cnt <= 8'h00;
         active_ts <= 5'h00;
      end else begin
         if (rst_start) begin
            rst_cnt <= `HTX_RST_BUSY; // R6
         end else if (rst_cnt != 8'h00) begin
            rst_cnt <= rst_cnt - 8'h01;
         end
         if (rst_done) begin
            active_ts <= ctrl2[4:0]; // R16
         end
      end
   end

   // FIFO storage, no reset needed on the array
   always_ff @(posedge core_clk) begin
      if (fifo_push) begin
         fifo_mem[wr_ptr[5:0]] <= {avs_writedata[7:0],
                                   ctrl1[`HTX_B_EOM] | ctrl1[`HTX_B_LOOP],
                                   ctrl1[`HTX_B_LOOP]}; // R9 R2
      end
   end

   // FIFO pointers and bit engine
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= 7'h00;
         rd_ptr <= 7'h00;
         base_ptr <= 7'h00;
         state <= htx_pkg::HTX_IDLE;
         sreg <= 8'h00;
         bits_left <= 4'h0;
         ones <= 3'h0;
         stuff_on <= 1'b0;
         crc_on <= 1'b0;
         crc <= 16'h0000;
         cur_eom <= 1'b0;
         cur_loop <= 1'b0;
      end else if (flush) begin
         wr_ptr <= 7'h00; // R5 R13
         rd_ptr <= 7'h00;
         base_ptr <= 7'h00;
         state <= htx_pkg::HTX_ABORT;
         sreg <= `HTX_ABORT_BYTE;
         bits_left <= 4'h8;
         ones <= 3'h0;
         stuff_on <= 1'b0;
         crc_on <= 1'b0;
         cur_eom <= 1'b0;
         cur_loop <= 1'b0;
      end else begin
         if (fifo_push) begin
            wr_ptr <= wr_ptr + 7'h01;
         end
         if (grant & stuff_now) begin
            ones <= 3'h0; // R11
         end else if (grant) begin
            sreg <= src_byte >> 1;
            bits_left <= at_bound ? 4'h7 : bits_left - 4'h1;
            ones <= (src_stuff & emit_bit) ? ones + 3'h1 : 3'h0;
            stuff_on <= src_stuff;
            crc_on <= src_crc;
            crc <= src_crc ? crc_step(src_crcv, emit_bit) : src_crcv;
            if (at_bound) begin
               state <= nb_state;
               if ((state == htx_pkg::HTX_CLOSE) & rewind) begin
                  rd_ptr <= base_ptr; // R2
               end
               if (nb_start) begin
                  base_ptr <= head_ptr;
               end else if (nb_state == htx_pkg::HTX_IDLE) begin
                  base_ptr <= rd_ptr; // R3
               end
               if (nb_pop) begin
                  rd_ptr <= head_ptr + 7'h01;
                  cur_eom <= head.eom;
                  cur_loop <= head.loop;
               end
            end
         end
      end
   end

   // Bit-oriented code: eight ones, zero, six code bits, zero, repeated
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         boc_sreg <= 16'h0000;
      end else if (!ctrl2[`HTX_B_BOC]) begin
         boc_sreg <= {1'b0, boc_code, 1'b0, `HTX_BOC_ONES};
      end else if (boc_go) begin
         boc_sreg <= {boc_sreg[0], boc_sreg[15:1]}; // R14
      end
   end

   // Registered output toward the framer
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_out <= 2'b00;
      end else begin
         tx_out.insert <= grant | boc_go;
         tx_out.data <= boc_go ? boc_sreg[0] : emit_bit;
      end
   end

endmodule
`default_nettype wire

// ### htx_tx_defs.svh
// Purpose: Offsets, field positions, codes and counts of the HDLC transmit controller
// Assumes: Register indices are word addresses on the Avalon-MM slave
// Notes: Definitions only
`ifndef HTX_TX_DEFS_SVH
`define HTX_TX_DEFS_SVH
// Register indices of port 1
`define HTX_IDX_CTRL1 12'h110
`define HTX_IDX_SUPP 12'h111
`define HTX_IDX_BOC 12'h112
`define HTX_IDX_CTRL2 12'h113
`define HTX_IDX_CFG 12'h115
`define HTX_IDX_FIFO 12'h116
`define HTX_IDX_STAT 12'h117
`define HTX_PORT_STRIDE 12'h200
// Control register one fields
`define HTX_B_FLAGS2 7
`define HTX_B_LOOP 6
`define HTX_B_SRST 5
`define HTX_B_MAP 4
`define HTX_B_FILL 3
`define HTX_B_EOM 2
`define HTX_B_NOSTUFF 1
`define HTX_B_NOCRC 0
// Control register two fields
`define HTX_B_ABORT 7
`define HTX_B_BOC 6
`define HTX_B_EN 5
// Local config fields
`define HTX_B_E1 0
`define HTX_B_FDLEN 1
// Line patterns
`define HTX_FLAG_BYTE 8'h7e
`define HTX_IDLE_BYTE 8'hff
`define HTX_ABORT_BYTE 8'hfe
`define HTX_CRC_INIT 16'hffff
`define HTX_CRC_POLY 16'h8408
`define HTX_BOC_ONES 8'hff
// Reset defaults and timing
`define HTX_RST_VAL 8'h00
`define HTX_RST_BUSY 8'h10
`endif

// ### htx_pkg.sv
// Purpose: Types shared by the HDLC transmit controller
// Assumes: Nothing beyond SystemVerilog packed types
// Notes: Constants live in htx_tx_defs.svh
package htx_pkg;
   typedef enum logic [2:0] {
      HTX_IDLE = 3'b000,
      HTX_FLAG = 3'b001,
      HTX_DATA = 3'b010,
      HTX_CRC_LO = 3'b011,
      HTX_CRC_HI = 3'b100,
      HTX_CLOSE = 3'b101,
      HTX_ABORT = 3'b110
   } htx_state_t;
   typedef struct packed {
      logic [7:0] data;
      logic eom;
      logic loop;
   } htx_entry_t;
   typedef struct packed {
      logic strobe;
      logic [4:0] timeslot;
      logic [2:0] bit_index;
      logic fdl_slot;
   } htx_slot_t;
   typedef struct packed {
      logic insert;
      logic data;
   } htx_out_t;
endpackage

// ### htx_framer_model.sv
// Purpose: Framer slot timing seen by the HDLC transmitter
// Assumes: Two channels of eight bits and one data-link bit per frame
// Notes: A short frame keeps runs brief; one line bit every other cycle
`timescale 1ns/100ps
`default_nettype none
module htx_framer_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Slot timing toward the controller
   output var htx_pkg::htx_slot_t tx_slot
);
   logic ph;
   logic [4:0] pos;
   wire fdl = (pos == 5'h10);
   // MSB first; the data-link slot shows a timeslot that no channel uses
   assign tx_slot = {ph, fdl ? 5'h1f : {4'h0, pos[3]}, ~pos[2:0], fdl};
   // Advance one line bit after each strobe
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ph <= 1'b0;
         pos <= 5'h00;
      end else begin
         ph <= !ph;
         if (ph)
            pos <= fdl ? 5'h00 : pos + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ### htx_tx_asserts.sv
// Purpose: Port-level checks of the HDLC transmit controller
// Assumes: Mirrors come from accepted writes
// Notes: Bound to every instance of the controller
`timescale 1ns/100ps
`default_nettype none
module htx_tx_asserts #(
   parameter logic [3:0] PORT_NUM = 4'd1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Register bus
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Line side
   input wire htx_pkg::htx_slot_t tx_slot,
   input wire htx_pkg::htx_out_t tx_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Decode relative to this port's copy
   wire [11:0] rel = avs_address - 12'h200 * ({8'h00, PORT_NUM} - 12'h001);
   wire wr_ok = avs_write && !avs_waitrequest;
   wire rd_ok = avs_read && !avs_waitrequest;
   wire mapped = rel inside {12'h110, 12'h111, 12'h112, 12'h113, 12'h115, 12'h117};
   logic en_q;
   logic [7:0] supp_q;
   logic [4:0] age;
   // Age saturates, so a late read of the reset bit must see it cleared
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         en_q <= 1'b0;
         supp_q <= 8'h00;
         age <= 5'h00;
      end else begin
         if (wr_ok && rel == 12'h113)
            en_q <= avs_writedata[5];
         if (wr_ok && rel == 12'h111)
            supp_q <= avs_writedata[7:0];
         if (wr_ok && rel == 12'h110 && avs_writedata[5])
            age <= 5'h00;
         else if (age != 5'h1f)
            age <= age + 5'h01;
      end
   end
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("bus answer not one cycle wide");
   property p_wait_cause;
      !avs_waitrequest |-> $past(avs_read || avs_write);
   endproperty
   a_wait_cause: assert property (p_wait_cause)
      else $error("bus answer without request");
   property p_insert_cause;
      tx_out.insert |-> $past(tx_slot.strobe);
   endproperty
   a_insert_cause: assert property (p_insert_cause)
      else $error("insert without strobe");
   property p_disabled;
      tx_slot.strobe && !en_q |=> !tx_out.insert;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("insert while disabled");
   property p_suppress;
      tx_slot.strobe && !tx_slot.fdl_slot && supp_q[tx_slot.bit_index] |=> !tx_out.insert;
   endproperty
   a_suppress: assert property (p_suppress)
      else $error("suppressed bit used");
   property p_srst_clear;
      rd_ok && rel == 12'h110 && age == 5'h1f |-> !avs_readdata[5];
   endproperty
   a_srst_clear: assert property (p_srst_clear)
      else $error("soft reset bit stuck");
   property p_unmapped;
      rd_ok && !mapped |-> avs_readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_supp_back;
      rd_ok && rel == 12'h111 |-> avs_readdata[7:0] == supp_q;
   endproperty
   a_supp_back: assert property (p_supp_back)
      else $error("suppress mask readback wrong");
   c_fifo: cover property (wr_ok && rel == 12'h116);
   c_srst: cover property (wr_ok && rel == 12'h110 && avs_writedata[5]);
   c_abort: cover property (wr_ok && rel == 12'h113 && avs_writedata[7]);
   c_insert: cover property (tx_out.insert);
endmodule
bind htx_hdlc_transmit_controller htx_tx_asserts #(.PORT_NUM(PORT_NUM)) htx_tx_asserts_inst (
   .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .tx_slot(tx_slot), .tx_out(tx_out));
`default_nettype wire

// ### htx_hdlc_transmit_controller_tb.sv
// Purpose: Self-checking bench of the HDLC transmit controller
// Assumes: Port 1 copy, slot timing from htx_framer_model
// Notes: Frames rebuilt from granted bits
`timescale 1ns/100ps
`default_nettype none
module htx_hdlc_transmit_controller_tb;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   htx_pkg::htx_slot_t tx_slot, prev;
   htx_pkg::htx_out_t tx_out;
   int bad_count = 0, num_checks = 0, ones = 0, nfrm = 0, nflag = 0, nabort = 0;
   int gap = 0, last_gap = 0, nins = 0, n0, a0, t;
   bit dbits[$];
   logic [7:0] frm[$], supp = 8'h00, c1 = 8'h00;
   logic [4:0] exp_ts = 5'h00;
   logic exp_map = 1'b0;
   always #20 core_clk = !core_clk;
   htx_framer_model htx_framer_model_inst (.core_clk(core_clk), .nrst(nrst), .tx_slot(tx_slot));
   htx_hdlc_transmit_controller #(.PORT_NUM(4'd1)) htx_hdlc_transmit_controller_inst (
      .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .tx_slot(tx_slot), .tx_out(tx_out));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      check(n < 64, 1'b1);
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check(q, {24'h0, e});
   endtask
   // Destuff, cut at flags, drop everything at seven ones
   task automatic rx_bit(input bit b);
      logic [7:0] v;
      if (!b && ones == 6) begin
         nflag++;
         if (dbits.size() > 7) begin
            frm = {};
            for (int k = 0; k < (dbits.size() - 7) / 8; k++) begin
               for (int j = 0; j < 8; j++) v[j] = dbits[8 * k + j];
               frm.push_back(v);
            end
            nfrm++;
            last_gap = gap;
            gap = 0;
         end else
            gap++;
         dbits = {};
      end else if (b || ones != 5)
         dbits.push_back(b);
      ones = b ? ones + 1 : 0;
      if (ones == 7)
         nabort++;
      if (ones >= 7)
         dbits = {};
   endtask
   // Every granted bit must sit in the expected place of the frame
   always @(posedge core_clk) begin
      prev <= tx_slot;
      if (tx_out.insert === 1'b1) begin
         nins++;
         if (exp_map)
            check(prev.fdl_slot, 1'b1);
         else
            check({prev.fdl_slot, prev.timeslot, supp[prev.bit_index]}, {1'b0, exp_ts, 1'b0});
         rx_bit(tx_out.data);
      end
   end
   function automatic logic [15:0] crc16(input logic [7:0] m[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (m[i])
         for (int j = 0; j < 8; j++)
            c = (c[0] ^ m[i][j]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      return ~c;
   endfunction
   task automatic wait_frm(input int tgt);
      t = 0;
      while (nfrm < tgt && t < 4000) begin
         @(posedge core_clk);
         t++;
      end
      check(nfrm >= tgt, 1'b1);
   endtask
   // End bit is set just before the last byte goes in
   task automatic send(input logic [7:0] m[$], input logic [7:0] c);
      foreach (m[i]) begin
         if (i == m.size() - 1)
            wr(12'h110, c | 8'h04);
         wr(12'h116, m[i]);
      end
   endtask
   task automatic msg(input logic [7:0] m[$]);
      logic [15:0] c;
      n0 = nfrm;
      send(m, c1);
      wait_frm(n0 + 1);
      c = crc16(m);
      if (!c1[0])
         m = {m, c[7:0], c[15:8]};
      check(frm.size(), m.size());
      foreach (m[i]) check(frm[i], m[i]);
   endtask
   // Disabling lets one granted bit drain
   task automatic off(input logic [7:0] ts);
      wr(12'h113, ts);
      repeat (2) @(posedge core_clk);
   endtask
   task automatic t_regs();
      rdchk(12'h110, 8'h00);
      rdchk(12'h113, 8'h00);
      wr(12'h111, 8'ha5);
      rdchk(12'h111, 8'ha5);
      wr(12'h111, 8'h00);
      rdchk(12'h114, 8'h00);
      rdchk(12'h311, 8'h00);
   endtask
   task automatic t_fill();
      wr(12'h113, 8'h20);
      n0 = nflag;
      repeat (400) @(posedge core_clk);
      check(nflag - n0 > 6, 1'b1);
      wr(12'h110, 8'h08);
      repeat (400) @(posedge core_clk);
      check(ones > 40, 1'b1);
      wr(12'h110, 8'h00);
   endtask
   task automatic t_frames();
      msg('{8'h3f, 8'hff, 8'h7e});
      c1 = 8'h01;
      msg('{8'h5a, 8'hf8});
      c1 = 8'h03;
      n0 = nfrm;
      send('{8'h1f, 8'h00}, c1);
      wait_frm(n0 + 1);
      check(frm.size(), 1);
      c1 = 8'h00;
      for (int f = 0; f < 2; f++) begin
         n0 = nfrm;
         send('{8'hc3}, {f[0], 7'h00});
         send('{8'h3c}, {f[0], 7'h00});
         wait_frm(n0 + 2);
         check(last_gap, f);
      end
   endtask
   task automatic t_loop();
      n0 = nfrm;
      send('{8'h81}, 8'h40);
      wait_frm(n0 + 3);
      check(frm[0], 8'h81);
      send('{8'h42}, 8'h40);
      t = 0;
      while (frm[0] !== 8'h42 && t < 3000) begin
         @(posedge core_clk);
         t++;
      end
      check(frm[0], 8'h42);
      wr(12'h110, 8'h00);
      n0 = nfrm;
      repeat (600) @(posedge core_clk);
      check(nfrm - n0 < 2, 1'b1);
   endtask
   task automatic t_abort();
      wr(12'h116, 8'h11);
      wr(12'h116, 8'h22);
      a0 = nabort;
      n0 = nfrm;
      wr(12'h113, 8'ha0);
      repeat (200) @(posedge core_clk);
      check(nabort - a0, 1);
      check(nfrm, n0);
      wr(12'h113, 8'h20);
      msg('{8'h33});
   endtask
   task automatic t_srst();
      logic [31:0] q;
      wr(12'h113, 8'h21);
      wr(12'h116, 8'h44);
      a0 = nabort;
      wr(12'h110, 8'h20);
      @(posedge core_clk);
      exp_ts = 5'h01;
      t = 0;
      do begin
         bus(1'b0, 12'h110, 8'h00, q);
         t++;
      end while (q[5] !== 1'b0 && t < 20);
      check(q[5], 1'b0);
      repeat (200) @(posedge core_clk);
      check(nabort - a0, 1);
      msg('{8'h55});
   endtask
   task automatic t_off();
      off(8'h01);
      n0 = nins;
      repeat (300) @(posedge core_clk);
      check(nins, n0);
      supp = 8'h81;
      wr(12'h111, supp);
      c1 = 8'h10;
      wr(12'h110, c1);
      wr(12'h115, 8'h02);
      exp_map = 1'b1;
      wr(12'h113, 8'h21);
      msg('{8'hc5});
      off(8'h01);
      exp_map = 1'b0;
      c1 = 8'h00;
      wr(12'h110, c1);
      wr(12'h113, 8'h21);
      msg('{8'h6b});
   endtask
   task automatic final_report();
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog: ten times the expected run
   initial begin
      #(40 * 80000);
      bad_count++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_fill();
      t_frames();
      t_loop();
      t_abort();
      t_srst();
      t_off();
      final_report();
   end
endmodule
`default_nettype wire
